/* verilog/dtd_pkg.sv */
package dtd_pkg;
	// Opcode bytes of the decoded data-transfer group.
	localparam logic [7:0] OP_TABLE_TRANSLATE = 8'hD7;
	localparam logic [7:0] OP_EFFECTIVE_ADDRESS_LOAD = 8'h8D;
	localparam logic [7:0] OP_FAR_POINTER_LOAD_DATA_SEG = 8'hC5;
	localparam logic [7:0] OP_FAR_POINTER_LOAD_EXTRA_SEG = 8'hC4;
	localparam logic [7:0] OP_FLAGS_TO_UPPER_ACC = 8'h9F;
	localparam logic [7:0] OP_UPPER_ACC_TO_FLAGS = 8'h9E;

	// ModR/M field positions.
	localparam int MODRM_MOD_HI = 7;
	localparam int MODRM_MOD_LO = 6;
	localparam logic [1:0] MOD_REGISTER = 2'h3;

	// Execution clock counts.
	localparam logic [4:0] CLK_TABLE_TRANSLATE = 5'h0F;
	localparam logic [4:0] CLK_EFFECTIVE_ADDRESS_LOAD = 5'h06;
	localparam logic [4:0] CLK_FAR_POINTER_LOAD = 5'h1A;
	localparam logic [4:0] CLK_FLAGS_TO_UPPER_ACC = 5'h02;
	localparam logic [4:0] CLK_UPPER_ACC_TO_FLAGS = 5'h03;

	// Operation codes reported to the core, one-hot.
	localparam logic [5:0] SEL_NONE = 6'h00;
	localparam logic [5:0] SEL_TABLE_TRANSLATE = 6'h01;
	localparam logic [5:0] SEL_EFFECTIVE_ADDRESS_LOAD = 6'h02;
	localparam logic [5:0] SEL_FAR_POINTER_LOAD_DATA_SEG = 6'h04;
	localparam logic [5:0] SEL_FAR_POINTER_LOAD_EXTRA_SEG = 6'h08;
	localparam logic [5:0] SEL_FLAGS_TO_UPPER_ACC = 6'h10;
	localparam logic [5:0] SEL_UPPER_ACC_TO_FLAGS = 6'h20;

	// Decoder states, one-hot.
	typedef enum logic [2:0]
	{
		ST_OPCODE = 3'h1,
		ST_MODRM = 3'h2,
		ST_EXECUTE = 3'h4
	} dtd_state_e;
endpackage

/* verilog/dtd_decoder.sv */
// Summary of operation
// RULE1: D7 is table translate; low accumulator byte is replaced; 15 clocks.
// RULE2: Byte 8D plus ModR/M loads effective address into register; 6 clocks.
// RULE3: C5 plus memory ModR/M loads far pointer, data segment; 26 clocks.
// RULE4: C4 plus memory ModR/M loads far pointer, extra segment; 26 clocks.
// RULE5: Byte 9F copies flags low byte into upper accumulator byte; 2 clocks.
// RULE6: Byte 9E loads flags low byte from upper accumulator byte; 3 clocks.
// RULE7: Far-pointer loads with mod 11 are invalid; no transfer happens.
module dtd_decoder
(
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	// Instruction byte stream from the fetch path.
	input wire logic [7:0] BYTE_DATA,
	input wire logic BYTE_VALID,
	output logic BYTE_READY,
	// Decoded operation towards the execution unit.
	output logic [5:0] OP_SELECT,
	output logic [7:0] OP_MODRM,
	output logic OP_START,
	output logic OP_BUSY,
	output logic OP_DONE,
	output logic OP_INVALID
);

	// Decoder state and the operation it has latched.
	dtd_pkg::dtd_state_e state_q, state_d;
	logic [5:0] sel_q, sel_d;
	logic [7:0] modrm_q;
	// Execution clocks still to run; loaded when execution starts.
	logic [4:0] count_q, count_d;
	// One-cycle pulses and the busy level, each held in its own flop.
	logic start_q, done_q, invalid_q;
	logic start_d, done_d, invalid_d;
	logic busy_q;

	// Clock count of an operation; one place so both entry paths agree.
	// Far-pointer loads share the last arm; a refused one never gets here.
	function automatic logic [4:0] op_clocks(input logic [5:0] sel);
		if (sel == dtd_pkg::SEL_TABLE_TRANSLATE)
			op_clocks = dtd_pkg::CLK_TABLE_TRANSLATE; // RULE1
		else if (sel == dtd_pkg::SEL_EFFECTIVE_ADDRESS_LOAD)
			op_clocks = dtd_pkg::CLK_EFFECTIVE_ADDRESS_LOAD; // RULE2
		else if (sel == dtd_pkg::SEL_FLAGS_TO_UPPER_ACC)
			op_clocks = dtd_pkg::CLK_FLAGS_TO_UPPER_ACC; // RULE5
		else if (sel == dtd_pkg::SEL_UPPER_ACC_TO_FLAGS)
			op_clocks = dtd_pkg::CLK_UPPER_ACC_TO_FLAGS; // RULE6
		else
			op_clocks = dtd_pkg::CLK_FAR_POINTER_LOAD; // RULE3 RULE4
	endfunction

	// Opcode decode; unknown bytes are left for other decoders.
	wire logic [5:0] sel_byte;
	wire logic needs_modrm;
	wire logic take_byte;
	wire logic mod_is_reg;
	wire logic far_load;

	assign sel_byte =
		(BYTE_DATA == dtd_pkg::OP_TABLE_TRANSLATE) ?
			dtd_pkg::SEL_TABLE_TRANSLATE : // RULE1
		(BYTE_DATA == dtd_pkg::OP_EFFECTIVE_ADDRESS_LOAD) ?
			dtd_pkg::SEL_EFFECTIVE_ADDRESS_LOAD : // RULE2
		(BYTE_DATA == dtd_pkg::OP_FAR_POINTER_LOAD_DATA_SEG) ?
			dtd_pkg::SEL_FAR_POINTER_LOAD_DATA_SEG : // RULE3
		(BYTE_DATA == dtd_pkg::OP_FAR_POINTER_LOAD_EXTRA_SEG) ?
			dtd_pkg::SEL_FAR_POINTER_LOAD_EXTRA_SEG : // RULE4
		(BYTE_DATA == dtd_pkg::OP_FLAGS_TO_UPPER_ACC) ?
			dtd_pkg::SEL_FLAGS_TO_UPPER_ACC : // RULE5
		(BYTE_DATA == dtd_pkg::OP_UPPER_ACC_TO_FLAGS) ?
			dtd_pkg::SEL_UPPER_ACC_TO_FLAGS : // RULE6
		dtd_pkg::SEL_NONE;

	// These three forms wait for a ModR/M byte before they can start.
	assign needs_modrm = (sel_byte == dtd_pkg::SEL_EFFECTIVE_ADDRESS_LOAD)
		|| (sel_byte == dtd_pkg::SEL_FAR_POINTER_LOAD_DATA_SEG)
		|| (sel_byte == dtd_pkg::SEL_FAR_POINTER_LOAD_EXTRA_SEG);
	// A byte moves only on an edge where both sides agree.
	assign take_byte = BYTE_VALID && BYTE_READY;
	// A mod field of 11 names a register, which a far load cannot use.
	assign mod_is_reg = BYTE_DATA[dtd_pkg::MODRM_MOD_HI:dtd_pkg::MODRM_MOD_LO]
		== dtd_pkg::MOD_REGISTER;
	// The ModR/M check applies only to the two far-pointer loads.
	assign far_load = (sel_q == dtd_pkg::SEL_FAR_POINTER_LOAD_DATA_SEG)
		|| (sel_q == dtd_pkg::SEL_FAR_POINTER_LOAD_EXTRA_SEG);

	// Next-state logic. The counter runs down the clock count of the
	// operation, taken as the whole time after its last byte. Displacement
	// bytes are not handled here; the fetch path must sequence them.
	always_comb
	begin
		state_d = state_q;
		sel_d = sel_q;
		count_d = count_q;
		// Pulses default low, so each one lasts a single cycle.
		start_d = 1'b0;
		done_d = 1'b0;
		invalid_d = 1'b0;
		case (state_q)
			// Waiting for an opcode byte.
			dtd_pkg::ST_OPCODE:
			begin
				// Unknown opcodes are taken and dropped; another decoder owns them.
				if (take_byte && (sel_byte != dtd_pkg::SEL_NONE))
				begin
					sel_d = sel_byte;
					if (needs_modrm)
						state_d = dtd_pkg::ST_MODRM;
					else
					begin
						// Single-byte forms start on the same edge that takes the opcode.
						state_d = dtd_pkg::ST_EXECUTE;
						count_d = op_clocks(sel_byte);
						start_d = 1'b1;
					end
				end
			end
			// Waiting for the ModR/M byte of a two-byte instruction.
			dtd_pkg::ST_MODRM:
			begin
				if (take_byte)
				begin
					if (far_load && mod_is_reg)
					begin
						// Rejected without any transfer being started; the core sees the
						// invalid pulse, a cleared selection and the refused byte on OP_MODRM.
						state_d = dtd_pkg::ST_OPCODE; // RULE7
						sel_d = dtd_pkg::SEL_NONE; // RULE7
						invalid_d = 1'b1; // RULE7
					end
					else
					begin
						// Accepted: start the operation latched at the opcode.
						state_d = dtd_pkg::ST_EXECUTE;
						count_d = op_clocks(sel_q);
						start_d = 1'b1;
					end
				end
			end
			// Counting down the execution clocks.
			dtd_pkg::ST_EXECUTE:
			begin
				count_d = count_q - 5'h01;
				if (count_q == 5'h01)
				begin
					// Done is raised as the last clock leaves.
					state_d = dtd_pkg::ST_OPCODE;
					done_d = 1'b1;
				end
			end
			// Unused codes fall back to the opcode state.
			default:
			begin
				state_d = dtd_pkg::ST_OPCODE;
			end
		endcase
	end

	// State and output registers. Reset leaves every pulse low and the
	// decoder waiting for an opcode.
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state_q <= dtd_pkg::ST_OPCODE;
			sel_q <= dtd_pkg::SEL_NONE;
			count_q <= 5'h00;
			start_q <= 1'b0;
			done_q <= 1'b0;
			invalid_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			sel_q <= sel_d;
			count_q <= count_d;
			start_q <= start_d;
			done_q <= done_d;
			invalid_q <= invalid_d;
		end
	end

	// The ModR/M byte is captured as it is taken. The opcode needs no copy
	// of its own, since the one-hot selection already names the operation.
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			modrm_q <= 8'h00;
		else if (take_byte && (state_q == dtd_pkg::ST_MODRM))
			modrm_q <= BYTE_DATA;
	end

	// Ready is registered from the next state. It falls on the edge that
	// starts execution, so no byte slips in while busy, and it rises with
	// done, so the next opcode may already be taken in that cycle.
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			BYTE_READY <= 1'b0;
		else
			BYTE_READY <= (state_d != dtd_pkg::ST_EXECUTE);
	end

	// Busy has a flop of its own rather than a compare on the state, so the
	// core never sees a decode glitch; it tracks the state edge for edge.
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			busy_q <= 1'b0;
		else
			busy_q <= (state_d == dtd_pkg::ST_EXECUTE);
	end

	// All outputs come from flip-flops. These are plain renames only; no
	// output passes through decode logic on its way out.
	assign OP_SELECT = sel_q;
	assign OP_MODRM = modrm_q;
	assign OP_START = start_q;
	assign OP_BUSY = busy_q;
	assign OP_DONE = done_q;
	assign OP_INVALID = invalid_q;

endmodule // dtd_decoder

/* verif/dtd_fetch_model.sv */
module dtd_fetch_model
(
	// Clock and handshake.
	input wire logic clk,
	input wire logic ready,
	// Offered byte.
	output logic [7:0] data,
	output logic valid,
	output logic hung
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released bus shows the inverse, so stale data never looks valid.
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk);
		valid <= 1'b1;
		data <= b;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ready !== 1'b1 && n < 60);
		hung <= hung | (n >= 60);
		valid <= 1'b0;
		data <= ~b;
	endtask
	// Idle fetch path at start.
	initial
	begin
		valid = 1'b0;
		data = 8'h00;
		hung = 1'b0;
	end
endmodule // dtd_fetch_model

/* verif/dtd_decoder_chk.sv */
module dtd_decoder_chk
(
	// Watched decoder ports.
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic BYTE_VALID,
	input wire logic BYTE_READY,
	input wire logic [5:0] OP_SELECT,
	input wire logic OP_START,
	input wire logic OP_BUSY,
	input wire logic OP_DONE,
	input wire logic OP_INVALID
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] n_q;
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);
	// Busy cycles so far; a stuck count shows up at done as a wrong length.
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			n_q <= 5'h00;
		else if (OP_START)
			n_q <= 5'h01;
		else if (OP_BUSY)
			n_q <= n_q + 5'h01;
	end
	// Length of one operation, judged in its done cycle.
	property len_p(logic [5:0] s, logic [4:0] n);
		OP_DONE && OP_SELECT == s |-> n_q == n;
	endproperty
	a_translate_len: assert property (len_p(6'h01, 5'h0F))
		else $error("bad length");
	a_ea_len: assert property (len_p(6'h02, 5'h06))
		else $error("bad length");
	a_far_data_len: assert property (len_p(6'h04, 5'h1A))
		else $error("bad length");
	a_far_extra_len: assert property (len_p(6'h08, 5'h1A))
		else $error("bad length");
	a_flags_up_len: assert property (len_p(6'h10, 5'h02))
		else $error("bad length");
	a_flags_down_len: assert property (len_p(6'h20, 5'h03))
		else $error("bad length");
	// Handshake and refusal checks.
	a_start_cause: assert property (
		OP_START |-> $past(BYTE_VALID && BYTE_READY))
		else $error("start without byte");
	a_invalid_quiet: assert property (
		OP_INVALID |-> !OP_START && !OP_BUSY && OP_SELECT == 6'h00)
		else $error("invalid not quiet");
	// Main scenarios reached.
	c_invalid: cover property (OP_INVALID);
	c_far_done: cover property (OP_DONE && OP_SELECT == 6'h04);
	c_translate_done: cover property (OP_DONE && OP_SELECT == 6'h01);
endmodule // dtd_decoder_chk
bind dtd_decoder dtd_decoder_chk chk_u (.CLK_SYS, .ARST_N, .BYTE_VALID,
	.BYTE_READY, .OP_SELECT, .OP_START, .OP_BUSY, .OP_DONE, .OP_INVALID);

/* verif/test_data_transfer_opcode_decode.sv */
module test_data_transfer_opcode_decode;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_SYS = 1'b0;
	logic ARST_N = 1'b0;
	logic [7:0] bdata, modrm;
	logic bvalid, bready, start, busy, done, inval, hung;
	logic [5:0] sel;
	int mismatches = 0;
	int checks = 0;
	// 25 MHz system clock.
	always #20 CLK_SYS = ~CLK_SYS;
	dtd_decoder dut_u (.CLK_SYS, .ARST_N, .BYTE_DATA(bdata),
		.BYTE_VALID(bvalid), .BYTE_READY(bready), .OP_SELECT(sel),
		.OP_MODRM(modrm), .OP_START(start), .OP_BUSY(busy),
		.OP_DONE(done), .OP_INVALID(inval));
	dtd_fetch_model fetch_u (.clk(CLK_SYS), .ready(bready), .data(bdata),
		.valid(bvalid), .hung);
	task automatic check(input string what, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Offers the opcode and, for two-byte forms, its ModR/M byte, then
	// settles just past the edge that took the last byte.
	task automatic issue(input logic [7:0] op, m, input logic two);
		fetch_u.send(op);
		if (two)
			fetch_u.send(m);
		#1;
	endtask
	// Busy is counted under a bound, so a hung decoder still ends the run.
	task automatic count_busy(output int n);
		n = 0;
		while (busy === 1'b1 && n < 40)
		begin
			n++;
			@(posedge CLK_SYS);
			#1;
		end
		if (n >= 40 || hung)
		begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	// Translate: one byte, fifteen clocks, no byte taken meanwhile.
	task automatic test_translate;
		int n;
		issue(8'hD7, 8'h00, 1'b0);
		check("start", 8'(start), 8'h01);
		check("select", 8'(sel), 8'h01);
		check("ready", 8'(bready), 8'h00);
		count_busy(n);
		check("clocks", 8'(n), 8'h0F);
		check("done", 8'(done), 8'h01);
	endtask
	// Effective address load starts after its ModR/M byte.
	task automatic test_ea_load;
		int n;
		issue(8'h8D, 8'h46, 1'b1);
		check("start", 8'(start), 8'h01);
		check("select", 8'(sel), 8'h02);
		count_busy(n);
		check("clocks", 8'(n), 8'h06);
		check("done", 8'(done), 8'h01);
		check("modrm", modrm, 8'h46);
	endtask
	// Far load with data segment, direct memory operand.
	task automatic test_far_data;
		int n;
		issue(8'hC5, 8'h06, 1'b1);
		check("start", 8'(start), 8'h01);
		check("select", 8'(sel), 8'h04);
		count_busy(n);
		check("clocks", 8'(n), 8'h1A);
		check("done", 8'(done), 8'h01);
	endtask
	// Far load with extra segment, memory operand with displacement mode.
	task automatic test_far_extra;
		int n;
		issue(8'hC4, 8'h80, 1'b1);
		check("start", 8'(start), 8'h01);
		check("select", 8'(sel), 8'h08);
		count_busy(n);
		check("clocks", 8'(n), 8'h1A);
		check("done", 8'(done), 8'h01);
	endtask
	// Flags into the upper accumulator byte.
	task automatic test_flags_up;
		int n;
		issue(8'h9F, 8'h00, 1'b0);
		check("start", 8'(start), 8'h01);
		check("select", 8'(sel), 8'h10);
		count_busy(n);
		check("clocks", 8'(n), 8'h02);
		check("done", 8'(done), 8'h01);
	endtask
	// Flags from the upper accumulator byte.
	task automatic test_flags_down;
		int n;
		issue(8'h9E, 8'h00, 1'b0);
		check("start", 8'(start), 8'h01);
		check("select", 8'(sel), 8'h20);
		count_busy(n);
		check("clocks", 8'(n), 8'h03);
		check("done", 8'(done), 8'h01);
	endtask
	// Far load with a register operand is refused and nothing starts.
	task automatic test_bad_far_load(input logic [7:0] op);
		issue(op, 8'hC0, 1'b1);
		check("invalid", 8'(inval), 8'h01);
		check("no start", 8'(start), 8'h00);
		check("busy", 8'(busy), 8'h00);
		check("select", 8'(sel), 8'h00);
		check("hung", 8'(hung), 8'h00);
	endtask
	// Reset, every opcode back to back, then both refused encodings.
	initial
	begin
		repeat (3) @(posedge CLK_SYS);
		ARST_N <= 1'b1;
		@(posedge CLK_SYS);
		test_translate();
		test_ea_load();
		test_far_data();
		test_far_extra();
		test_flags_up();
		test_flags_down();
		test_bad_far_load(8'hC5);
		test_bad_far_load(8'hC4);
		tally_and_finish();
	end
endmodule // test_data_transfer_opcode_decode
